// [hdl/itir_command_regs.v]
// command register logic for the input start/stop thresholds and the
// switching phase placement of one power stage.
// assumes: the pmbus framing logic in front hands over decoded word reads
// and writes as one-cycle strobes; nvm contents arrive as plain words; the
// comparator and enable levels are synchronous to sys_clk.
//
// Contract
// - command 35h holds start voltage as slinear11 word, read/write, effective at once
// - start word: bits 15:11 exponent reset 11110b, bits 10:0 mantissa from nvm
// - out-of-range write to 35h/36h/37h flags unsupported data and notifies host
// - unrepresentable thresholds round down, on write, power-on restore and 16h restore
// - start threshold hardware covers 2.50 v to 18.25 v in 0.25 v steps
// - stop threshold hardware covers 2.25 v to 18.25 v in 0.25 v steps
// - low-input fault stays masked until input first exceeds start threshold
// - enable toggles and nvm store/restore never re-arm that masking
// - command 36h holds stop voltage as slinear11 word, reset exponent 11110b
// - enabled conversion with input below stop threshold sets off-due-to-low-input flag
// - command 37h sets sync phase delay; writable only standalone, always readable
// - phase word bits 15:12 are unused, read only, return zero
// - phase word bits 11:8 hold group identifier 0h..fh from nvm
// - phase word bits 7:4 hold group count, legal 1h..4h
// - phase word bits 3:0 hold order, legal zero to count minus one
// - phase delay equals 360 degrees divided by count times order
// - phase command is read only inside a multi-phase stack
// - phase write permission fixed from stack config sampled at power-on only
`include "itir_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module itir_command_regs (
    // clock and reset
    input  wire        sys_clk,
    input  wire        rst_b,
    // decoded word transactions
    input  wire        cmd_write,
    input  wire        cmd_read,
    input  wire [7:0]  cmd_code,
    input  wire [15:0] cmd_write_data,
    output reg  [15:0] cmd_read_data,
    output reg         cmd_read_valid,
    // nvm restore
    input  wire        nvm_restore,
    input  wire [15:0] nvm_start_word,
    input  wire [15:0] nvm_stop_word,
    input  wire [15:0] nvm_phase_word,
    // stack configuration level, sampled once after reset
    input  wire        vendor_command_ec_multi,
    // unsupported data status
    input  wire        status_clear,
    output reg         invalid_data_status,
    output reg         host_notify,
    // input monitoring
    input  wire        power_input_above_start,
    input  wire        input_undervoltage_raw,
    input  wire        conversion_enable_met,
    input  wire        power_input_below_stop,
    output wire        input_undervoltage_fault,
    output reg         off_low_input_status,
    // hardware settings
    output reg  [6:0]  start_level_steps,
    output reg  [6:0]  stop_level_steps,
    output reg  [8:0]  phase_delay_deg,
    output wire        phase_write_locked
);

    // =====================================================================
    // storage
    reg  [15:0] conversion_start_voltage;
    reg  [15:0] conversion_stop_voltage;
    reg  [15:0] phase_placement;
    reg         load_pending;      // first cycle after reset loads nvm
    reg         stack_member;      // latched stack configuration
    reg         fault_armed;       // low-input fault unmasked

    // =====================================================================
    // slinear11 to quarter-volt steps, floored
    // exponents give shifts from -14 to +17; a 32-bit result holds both ends
    function signed [31:0] itir_quarter_steps;
        input [15:0] word;
        reg signed [31:0] mant;
        reg signed [5:0]  shift;
        reg        [5:0]  right;
        begin
            mant  = {{21{word[`ITIR_MAN_MSB]}}, word[`ITIR_MAN_MSB:`ITIR_MAN_LSB]};
            shift = $signed({word[`ITIR_EXP_MSB], word[`ITIR_EXP_MSB:`ITIR_EXP_LSB]})
                    + `ITIR_STEP_SHIFT;
            right = 6'h00 - shift;
            // arithmetic right shift floors, which is the round-down we want
            if (shift[5]) begin
                itir_quarter_steps = mant >>> right;
            end else begin
                itir_quarter_steps = mant <<< shift[4:0];
            end
        end
    endfunction

    // clamp a step count into the hardware range
    // the upper bound is shared by both thresholds, only the floor differs
    function [6:0] itir_clamp;
        input signed [31:0] steps;
        input signed [31:0] low;
        begin
            if (steps < low) begin
                itir_clamp = low[6:0];
            end else if (steps > `ITIR_MAX_STEPS) begin
                itir_clamp = 7'h49;
            end else begin
                itir_clamp = steps[6:0];
            end
        end
    endfunction

    // =====================================================================
    // decode of the incoming write
    wire signed [31:0] wr_steps = itir_quarter_steps(cmd_write_data);
    wire [3:0] wr_count = cmd_write_data[`ITIR_PH_COUNT_MSB:`ITIR_PH_COUNT_LSB];
    wire [3:0] wr_order = cmd_write_data[`ITIR_PH_ORDER_MSB:`ITIR_PH_ORDER_LSB];

    // one strobe per cycle; codes outside the three match nothing and are
    // dropped without a status, as for any command this block does not own
    wire wr_start = cmd_write && (cmd_code == `ITIR_CMD_START_VOLTAGE);
    wire wr_stop  = cmd_write && (cmd_code == `ITIR_CMD_STOP_VOLTAGE);
    wire wr_phase = cmd_write && (cmd_code == `ITIR_CMD_PHASE_PLACEMENT);

    // legality is judged after round-down, so a value a little above the top
    // step is still taken, at the top step; negative values never pass
    wire start_ok = (wr_steps >= `ITIR_START_MIN_STEPS)
                    && (wr_steps <= `ITIR_MAX_STEPS);
    wire stop_ok  = (wr_steps >= `ITIR_STOP_MIN_STEPS)
                    && (wr_steps <= `ITIR_MAX_STEPS);
    // phase legality: count 1..4 and order below count, and no write at all
    // from a stack member
    wire phase_ok = (wr_count >= `ITIR_PH_COUNT_MIN)
                    && (wr_count <= `ITIR_PH_COUNT_MAX)
                    && (wr_order < wr_count)
                    && !stack_member;

    // every refused write, of any of the three kinds, is reported alike
    // and leaves the stored word as it was
    wire bad_write = (wr_start && !start_ok) || (wr_stop && !stop_ok)
                     || (wr_phase && !phase_ok);

    // restore source: power-on load or a later restore command; a write that
    // meets a restore in the same cycle is dropped, but a bad one is still reported
    wire do_restore = load_pending || nvm_restore;

    // restored levels: the nvm image is rounded down, then clamped into the
    // hardware range, since a damaged image must still leave a usable level
    wire [6:0] nvm_start_level = itir_clamp(itir_quarter_steps(nvm_start_word),
                                            `ITIR_START_MIN_STEPS);
    wire [6:0] nvm_stop_level  = itir_clamp(itir_quarter_steps(nvm_stop_word),
                                            `ITIR_STOP_MIN_STEPS);

    assign phase_write_locked = stack_member;

    // =====================================================================
    // power-on capture of the stack configuration; later changes are ignored
    // so a running stack cannot have its phase alignment opened up
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            load_pending <= 1'b1;
            stack_member <= 1'b0;
        end else begin
            load_pending <= 1'b0;
            if (load_pending) begin
                stack_member <= vendor_command_ec_multi;
            end
        end
    end

    // =====================================================================
    // start and stop threshold words and their hardware levels
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            conversion_start_voltage <= {`ITIR_EXP_RESET, `ITIR_MAN_RESET};
            conversion_stop_voltage  <= {`ITIR_EXP_RESET, `ITIR_MAN_RESET};
            start_level_steps        <= 7'h0a;
            stop_level_steps         <= 7'h09;
        end else if (do_restore) begin
            // the word reads back at its fixed exponent with the level really
            // applied, so a restored word shows no finer value than the hardware holds; a written word reads back as written
            conversion_start_voltage <= {`ITIR_EXP_RESET, 4'h0, nvm_start_level};
            conversion_stop_voltage  <= {`ITIR_EXP_RESET, 4'h0, nvm_stop_level};
            start_level_steps        <= nvm_start_level;
            stop_level_steps         <= nvm_stop_level;
        end else begin
            if (wr_start && start_ok) begin
                conversion_start_voltage <= cmd_write_data;
                start_level_steps        <= wr_steps[6:0];
            end
            if (wr_stop && stop_ok) begin
                conversion_stop_voltage <= cmd_write_data;
                stop_level_steps        <= wr_steps[6:0];
            end
        end
    end

    // =====================================================================
    // phase placement word; the unused nibble is never stored
    // an illegal restored image is kept as it is; the delay table below then
    // falls back to sync rather than guessing at a position
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            phase_placement <= `ITIR_PH_RESET;
        end else if (do_restore) begin
            phase_placement <= {4'h0, nvm_phase_word[11:0]};
        end else if (wr_phase && phase_ok) begin
            phase_placement <= {4'h0, cmd_write_data[11:0]};
        end
    end

    // =====================================================================
    // phase delay lookup: full turn split by the count, times the order
    // a table rather than a divider: only ten legal pairs exist, and it puts
    // no arithmetic in the clock path
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            phase_delay_deg <= 9'h000;
        end else begin
            case (phase_placement[7:0])
                8'h21:   phase_delay_deg <= `ITIR_FULL_TURN_DEG >> 1;
                8'h31:   phase_delay_deg <= 9'h078;
                8'h32:   phase_delay_deg <= 9'h0f0;
                8'h41:   phase_delay_deg <= `ITIR_FULL_TURN_DEG >> 2;
                8'h42:   phase_delay_deg <= `ITIR_FULL_TURN_DEG >> 1;
                8'h43:   phase_delay_deg <= 9'h10e;
                // order zero, and any illegal restored image, sits at sync
                default: phase_delay_deg <= 9'h000;
            endcase
        end
    end

    // =====================================================================
    // word read answer, one cycle after the strobe
    // a read in the cycle of a write returns the value held before that write
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            cmd_read_data  <= 16'h0000;
            cmd_read_valid <= 1'b0;
        end else begin
            cmd_read_valid <= cmd_read;
            if (cmd_read) begin
                case (cmd_code)
                    `ITIR_CMD_START_VOLTAGE:   cmd_read_data <= conversion_start_voltage;
                    `ITIR_CMD_STOP_VOLTAGE:    cmd_read_data <= conversion_stop_voltage;
                    `ITIR_CMD_PHASE_PLACEMENT: cmd_read_data <= phase_placement;
                    default:                   cmd_read_data <= 16'h0000;
                endcase
            end
        end
    end

    // =====================================================================
    // unsupported data status; a new bad write beats a clear in the same cycle
    // host_notify is a one-cycle pulse per refused write and may be missed,
    // so the sticky flag is what the host should poll
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            invalid_data_status <= 1'b0;
            host_notify         <= 1'b0;
        end else begin
            host_notify <= bad_write;
            if (bad_write) begin
                invalid_data_status <= 1'b1;
            end else if (status_clear) begin
                invalid_data_status <= 1'b0;
            end
        end
    end

    // =====================================================================
    // low-input fault masking: armed once per reset, nothing else disarms it,
    // so enable toggles and nvm traffic leave it alone
    // limitation: an input that never reaches the start level stays silent
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            fault_armed <= 1'b0;
        end else if (power_input_above_start) begin
            fault_armed <= 1'b1;
        end
    end

    assign input_undervoltage_fault = input_undervoltage_raw && fault_armed;

    // =====================================================================
    // output off due to low input; sticky, set wins over clear
    // enable and below-stop are plain levels; the flag rises the cycle after both
    always @(posedge sys_clk) begin
        if (!rst_b) begin
            off_low_input_status <= 1'b0;
        end else if (conversion_enable_met && power_input_below_stop) begin
            off_low_input_status <= 1'b1;
        end else if (status_clear) begin
            off_low_input_status <= 1'b0;
        end
    end

endmodule // itir_command_regs

`default_nettype wire

// [hdl/itir_regs.vh]
// input threshold and phase placement command constants
// assumes: included by the command register logic, no other definitions needed
`ifndef ITIR_REGS_VH
`define ITIR_REGS_VH

// =====================================================================
// command codes
`define ITIR_CMD_START_VOLTAGE   8'h35
`define ITIR_CMD_STOP_VOLTAGE    8'h36
`define ITIR_CMD_PHASE_PLACEMENT 8'h37

// =====================================================================
// slinear11 word layout
`define ITIR_EXP_MSB             15
`define ITIR_EXP_LSB             11
`define ITIR_MAN_MSB             10
`define ITIR_MAN_LSB             0
`define ITIR_EXP_RESET           5'h1e
`define ITIR_MAN_RESET           11'h000

// =====================================================================
// hardware threshold steps, in counts of 0.25 v
`define ITIR_STEP_SHIFT          6'sh02
`define ITIR_START_MIN_STEPS     32'sh0000000a
`define ITIR_STOP_MIN_STEPS      32'sh00000009
`define ITIR_MAX_STEPS           32'sh00000049

// =====================================================================
// phase placement word layout
`define ITIR_PH_UNUSED_MSB       15
`define ITIR_PH_UNUSED_LSB       12
`define ITIR_PH_GROUP_MSB        11
`define ITIR_PH_GROUP_LSB        8
`define ITIR_PH_COUNT_MSB        7
`define ITIR_PH_COUNT_LSB        4
`define ITIR_PH_ORDER_MSB        3
`define ITIR_PH_ORDER_LSB        0
`define ITIR_PH_COUNT_MIN        4'h1
`define ITIR_PH_COUNT_MAX        4'h4
`define ITIR_PH_RESET            16'h0010
`define ITIR_FULL_TURN_DEG       9'h168

`endif

// [verification/itir_host_model.sv]
// host controller model issuing decoded word writes and reads
// assumes: strobes taken on the rising edge, read answered one cycle later
`timescale 1ns/1ps
`default_nettype none
// ==============================================================
// host model
module itir_host_model (
    // clock
    input  wire logic        sys_clk,
    // word transactions
    output var logic         cmd_write,
    output var logic         cmd_read,
    output var logic [7:0]   cmd_code,
    output var logic [15:0]  cmd_write_data,
    input  wire logic [15:0] cmd_read_data,
    input  wire logic        cmd_read_valid
);
    initial {cmd_write, cmd_read, cmd_code, cmd_write_data} = 26'h0;
    // released lines show the inverse, so stale data never looks valid
    task automatic wr(input logic [7:0] code, input logic [15:0] data);
        @(posedge sys_clk);
        {cmd_write, cmd_code, cmd_write_data} <= {1'b1, code, data};
        @(posedge sys_clk);
        {cmd_write, cmd_code, cmd_write_data} <= {1'b0, ~code, ~data};
        @(posedge sys_clk);
        #1;
    endtask
    // an unanswered read hands back unknowns so the caller sees it
    task automatic rd(input logic [7:0] code, output logic [15:0] data);
        @(posedge sys_clk);
        {cmd_read, cmd_code} <= {1'b1, code};
        @(posedge sys_clk);
        {cmd_read, cmd_code} <= {1'b0, ~code};
        #1;
        data = cmd_read_valid ? cmd_read_data : 16'hxxxx;
    endtask
endmodule // itir_host_model
`default_nettype wire

// [verification/itir_regs_monitor.sv]
// checker for the threshold and phase command registers
// assumes: bound to itir_command_regs, one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
// ==============================================================
// port watcher
module itir_regs_monitor (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_b,
    // word transactions
    input wire logic        cmd_write,
    input wire logic        cmd_read,
    input wire logic [7:0]  cmd_code,
    input wire logic [15:0] cmd_write_data,
    input wire logic [15:0] cmd_read_data,
    input wire logic        cmd_read_valid,
    input wire logic        nvm_restore,
    // status and monitoring
    input wire logic        host_notify,
    input wire logic        invalid_data_status,
    input wire logic        power_input_above_start,
    input wire logic        input_undervoltage_fault,
    input wire logic        conversion_enable_met,
    input wire logic        power_input_below_stop,
    input wire logic        off_low_input_status,
    // hardware settings
    input wire logic [6:0]  stop_level_steps,
    input wire logic [8:0]  phase_delay_deg,
    input wire logic        phase_write_locked
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    // high once the input has been above the start level since reset
    logic seen;
    always_ff @(posedge sys_clk) seen <= rst_b & (seen | power_input_above_start);

    read_answer_a: assert property (cmd_read |=> cmd_read_valid)
        else $error("read not answered");
    unused_zero_a: assert property (cmd_read && cmd_code == 8'h37
            |=> cmd_read_data[15:12] == 4'h0)
        else $error("unused phase bits not zero");
    start_refuse_a: assert property (cmd_write && !nvm_restore && cmd_code == 8'h35
            && cmd_write_data[15:11] == 5'h1e
            && cmd_write_data[10:0] inside {[11'h04a:11'h3ff]}
            |=> host_notify && invalid_data_status)
        else $error("start level above range not refused");
    stop_accept_a: assert property (cmd_write && !nvm_restore && cmd_code == 8'h36
            && cmd_write_data[15:11] == 5'h1e
            && cmd_write_data[10:0] inside {[11'h009:11'h049]}
            |=> stop_level_steps == $past(cmd_write_data[6:0]) && !host_notify)
        else $error("stop level not applied");
    // the delay lags the stored word by one more register stage
    phase_delay_a: assert property (cmd_write && !nvm_restore && !phase_write_locked
            && cmd_code == 8'h37 && cmd_write_data[7:0] == 8'h43
            |-> ##2 phase_delay_deg == 9'h10e)
        else $error("phase delay wrong for order 3 of 4");
    locked_write_a: assert property (cmd_write && !nvm_restore && phase_write_locked
            && cmd_code == 8'h37 |=> host_notify && $stable(phase_delay_deg))
        else $error("locked phase write not refused");
    // the lock is latched at the first edge after release, so wait two settled cycles
    lock_fixed_a: assert property ($past(rst_b) && $past(rst_b, 2)
            |-> $stable(phase_write_locked))
        else $error("phase lock changed after power-on");
    mask_hold_a: assert property (!seen |-> !input_undervoltage_fault)
        else $error("low input fault before first start");
    off_low_a: assert property (conversion_enable_met && power_input_below_stop |=> off_low_input_status)
        else $error("off due to low input not flagged");

    cover property (host_notify);
    cover property (cmd_read_valid);
    cover property (input_undervoltage_fault);
endmodule // itir_regs_monitor

bind itir_command_regs itir_regs_monitor u_mon (.*);
`default_nettype wire

// [verification/itir_testbench.sv]
// self-checking bench for the threshold and phase command registers
// assumes: host model and checker compiled first, 40 mhz clock
`timescale 1ns/1ps
`default_nettype none
// ==============================================================
// bench top
module testbench;
    logic        sys_clk, rst_b, nvm_restore, vendor_command_ec_multi, status_clear;
    logic        power_input_above_start, input_undervoltage_raw;
    logic        conversion_enable_met, power_input_below_stop;
    logic [15:0] nvm_start_word, nvm_stop_word, nvm_phase_word, d;
    wire         cmd_write, cmd_read, cmd_read_valid, invalid_data_status, host_notify;
    wire         input_undervoltage_fault, off_low_input_status, phase_write_locked;
    wire [7:0]   cmd_code;
    wire [15:0]  cmd_write_data, cmd_read_data;
    wire [6:0]   start_level_steps, stop_level_steps;
    wire [8:0]   phase_delay_deg;
    int          errors, samples_checked;
    logic [7:0]  cfg [7] = '{8'h10, 8'h21, 8'h31, 8'h32, 8'h41, 8'h42, 8'h43};

    itir_command_regs u_dut (.*);
    itir_host_model u_host (.*);

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic do_reset;
        @(posedge sys_clk) rst_b <= 1'b0;
        repeat (16) @(posedge sys_clk);
        rst_b <= 1'b1;
        settle(2);
    endtask
    // top step accepted, one above refused, finer exponent rounded down
    task automatic s_thresholds;
        u_host.wr(8'h35, 16'hf049);
        chk(16'(start_level_steps), 16'h0049);
        u_host.wr(8'h35, 16'hf04a);
        chk(16'(start_level_steps), 16'h0049);
        chk(16'(invalid_data_status), 16'h0001);
        @(posedge sys_clk) status_clear <= 1'b1;
        @(posedge sys_clk) status_clear <= 1'b0;
        settle(1);
        chk(16'(invalid_data_status), 16'h0000);
        u_host.wr(8'h35, 16'he02f);
        chk(16'(start_level_steps), 16'h000b);
        u_host.wr(8'h35, 16'hf00b);
        u_host.rd(8'h35, d);
        chk(d, 16'hf00b);
        u_host.wr(8'h36, 16'hf009); // stop kept below start
        chk(16'(stop_level_steps), 16'h0009);
        u_host.wr(8'h36, 16'hf008);
        chk(16'(stop_level_steps), 16'h0009);
    endtask
    // every legal count with each nonzero order, order zero only at count one; writable since power-on was standalone
    task automatic s_phase;
        for (int i = 0; i < 7; i++) begin
            u_host.wr(8'h37, {8'hfa, cfg[i]});
            u_host.rd(8'h37, d);
            chk(d, {8'h0a, cfg[i]});
            chk(16'(phase_delay_deg), 16'((360 / cfg[i][7:4]) * cfg[i][3:0]));
        end
        u_host.wr(8'h37, 16'h0050);
        u_host.wr(8'h37, 16'h0022);
        u_host.rd(8'h37, d);
        chk(d, 16'h0a43);
    endtask
    // fault masked until first start, a restore must not mask it again
    task automatic s_monitor;
        @(posedge sys_clk) input_undervoltage_raw <= 1'b1;
        settle(1);
        chk(16'(input_undervoltage_fault), 16'h0000);
        @(posedge sys_clk) power_input_above_start <= 1'b1;
        repeat (2) @(posedge sys_clk);
        power_input_above_start <= 1'b0;
        nvm_restore <= 1'b1;
        @(posedge sys_clk) nvm_restore <= 1'b0;
        {conversion_enable_met, power_input_below_stop} <= 2'b11;
        settle(2);
        chk(16'(input_undervoltage_fault), 16'h0001);
        chk(16'(off_low_input_status), 16'h0001);
        chk(16'(start_level_steps), 16'h000c);
    endtask
    // stack member at power-on: phase word frozen even after config drops
    task automatic s_lock;
        @(posedge sys_clk) vendor_command_ec_multi <= 1'b1;
        do_reset;
        chk(16'(input_undervoltage_fault), 16'h0000);
        @(posedge sys_clk) vendor_command_ec_multi <= 1'b0;
        u_host.wr(8'h37, 16'h0021);
        u_host.rd(8'h37, d);
        chk(d, 16'h0310);
        chk(16'(invalid_data_status), 16'h0001);
        chk(16'(phase_write_locked), 16'h0001);
    endtask

    initial begin
        {rst_b, nvm_restore, vendor_command_ec_multi, status_clear} = 4'h0;
        {power_input_above_start, input_undervoltage_raw} = 2'b00;
        {conversion_enable_met, power_input_below_stop} = 2'b00;
        nvm_start_word = 16'he031; // 3.0625 v, restores as 12 steps
        nvm_stop_word = 16'hf00a;
        nvm_phase_word = 16'h0310;
        do_reset;
        chk(16'(start_level_steps), 16'h000c);
        chk(16'(stop_level_steps), 16'h000a);
        u_host.rd(8'h35, d);
        chk(d, 16'hf00c);
        u_host.rd(8'h36, d);
        chk(d, 16'hf00a);
        s_thresholds;
        s_phase;
        s_monitor;
        s_lock;
        wrap_up;
    end
    // cut a hang short; the run needs well under a thousand cycles
    initial begin
        repeat (4000) @(posedge sys_clk);
        errors++;
        wrap_up;
    end
endmodule // testbench
`default_nettype wire
